// ### rtl/fir_feature_bank.sv
// Functional notes
// RULE1 - Cipher field reads 0x2 when the crypto extension is built in.
// RULE2 - All feature registers are 64 bits and read-only; writes change nothing.
// RULE3 - Release-consistent load-acquire field [23:20] reads 0x1.
// RULE4 - Persistence clean field [3:0] reads 0x1.
// RULE5 - Small and large granule fields both read 0x0, supported.
// RULE6 - Mid granule field [23:20] reads 0x1.
// RULE7 - User-only endian field [19:16] reads 0x0, fixed endianness.
// RULE8 - Secure split [15:12] and mixed endian [11:8] read 0x1.
// RULE9 - Address space id width [7:4] reads 0x2, sixteen bits.
// RULE10 - Physical range [3:0] reads 0x5, 48-bit space.
// RULE11 - Stage-2 execute split [31:28] reads 0x1.
// RULE12 - Speculative error field [27:24] reads 0x0.
// RULE13 - Privileged access never field [23:20] reads 0x2.
// RULE14 - Ordering region field [19:16] reads 0x1.
// RULE15 - Hierarchical disable field [15:12] reads 0x2.
// RULE16 - Host extension field [11:8] reports supported.
// RULE17 - VM id width field [7:4] reads 0x2.
// RULE18 - Hardware flag update field [3:0] reads 0x2.
// RULE19 - Enhanced trap field [59:56] reads 0x1.
// RULE20 - Virtual range field [19:16] reads 0x0, 48-bit addresses.
// RULE21 - Implicit barrier [15:12] reads 0x1; ordering field [11:8] reads 0x0.
// RULE22 - Multi load/store ordering field reports neither enable supported.
// RULE23 - User override [7:4] and common shared [3:0] read 0x1.
// RULE24 - Reserved fields read zero; writes to feature registers have no effect.
`timescale 1ns/1ns
`default_nettype none
module fir_feature_bank #(
  parameter bit CRYPTO_PRESENT = 1'b1
) (
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire logic [fir_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [fir_pkg::DATA_W-1:0] regWrData,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output var  logic [fir_pkg::DATA_W-1:0] regRdData,
  output var  logic                       roWriteSeen
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [fir_pkg::DATA_W-1:0]   instrAttr0;
  logic [fir_pkg::DATA_W-1:0]   instrAttr1;
  logic [fir_pkg::DATA_W-1:0]   memModel0;
  logic [fir_pkg::DATA_W-1:0]   memModel1;
  logic [fir_pkg::DATA_W-1:0]   memModel2;
  logic [fir_pkg::NUM_FEAT-1:0][fir_pkg::DATA_W-1:0] featTable;
  logic                         hitFeat;
  logic                         hitCtrl;
  logic                         hitStatus;
  logic                         hitLocal;
  logic                         featWrite;
  logic                         unmapAccess;
  logic                         statusClear;
  logic [fir_pkg::NUM_FEAT-1:0] featSel;
  logic [1:0]                   ctrl_reg;
  logic [1:0]                   ctrl_next;
  logic [fir_pkg::CNT_W-1:0]    ignoreCnt_reg;
  logic [fir_pkg::CNT_W-1:0]    ignoreCnt_next;
  logic [fir_pkg::NUM_FEAT-1:0] hitSticky_reg;
  logic [fir_pkg::NUM_FEAT-1:0] hitSticky_next;
  logic                         unmap_reg;
  logic                         unmap_next;
  logic                         roSeen_next;
  logic [fir_pkg::DATA_W-1:0]   localWord;
  logic [3:0]                   cipherVal;
  logic [3:0]                   hashVal;
  logic                         trackOn;
  logic                         satOn;

  // ****************************************
  // Build option
  // ****************************************
  // Cipher and hash fields follow the build option only
  // Without the extension all three fields read as absent
  always_comb begin
    if (CRYPTO_PRESENT) begin
      cipherVal = fir_pkg::CIPHER_ON_VAL; // RULE1
      hashVal   = fir_pkg::HASH_ON_VAL;
    end else begin
      cipherVal = fir_pkg::ABSENT_VAL;
      hashVal   = fir_pkg::ABSENT_VAL;
    end
  end

  // ****************************************
  // Instruction attributes 0
  // ****************************************
  // Every word starts at zero so reserved bits stay zero
  always_comb begin
    instrAttr0 = '0; // RULE24
    instrAttr0[fir_pkg::DOT_LSB +: fir_pkg::FLD_W]    = fir_pkg::DOT_VAL;
    instrAttr0[fir_pkg::RDM_LSB +: fir_pkg::FLD_W]    = fir_pkg::RDM_VAL;
    instrAttr0[fir_pkg::ATOMIC_LSB +: fir_pkg::FLD_W] = fir_pkg::ATOMIC_VAL;
    instrAttr0[fir_pkg::CRC_LSB +: fir_pkg::FLD_W]    = fir_pkg::CRC_VAL;
    instrAttr0[fir_pkg::HASH2_LSB +: fir_pkg::FLD_W]  = hashVal;
    instrAttr0[fir_pkg::HASH1_LSB +: fir_pkg::FLD_W]  = hashVal;
    instrAttr0[fir_pkg::CIPHER_LSB +: fir_pkg::FLD_W] = cipherVal; // RULE1
  end

  // ****************************************
  // Instruction attributes 1
  // ****************************************
  always_comb begin
    instrAttr1 = '0; // RULE24
    // Only two fields are defined; the rest is reserved
    // RULE3
    instrAttr1[fir_pkg::RC_LOAD_ACQ_LSB +: fir_pkg::FLD_W] = fir_pkg::RC_LOAD_ACQ_VAL;
    // RULE4
    instrAttr1[fir_pkg::PERSIST_CLEAN_LSB +: fir_pkg::FLD_W] = fir_pkg::PERSIST_CLEAN_VAL;
  end

  // ****************************************
  // Memory model 0
  // ****************************************
  always_comb begin
    memModel0 = '0; // RULE24
    // Fixed at build time; nothing in this word is writable
    // RULE5
    memModel0[fir_pkg::SMALL_GRAN_LSB +: fir_pkg::FLD_W] = fir_pkg::GRAN_4_64_VAL;
    // RULE5
    memModel0[fir_pkg::LARGE_GRAN_LSB +: fir_pkg::FLD_W] = fir_pkg::GRAN_4_64_VAL;
    // RULE6
    memModel0[fir_pkg::MID_GRAN_LSB +: fir_pkg::FLD_W] = fir_pkg::MID_GRAN_VAL;
    // RULE7
    memModel0[fir_pkg::USER_ENDIAN_LSB +: fir_pkg::FLD_W] = fir_pkg::USER_ENDIAN_VAL;
    // RULE8
    memModel0[fir_pkg::SEC_SPLIT_LSB +: fir_pkg::FLD_W] = fir_pkg::SEC_SPLIT_VAL;
    // RULE8
    memModel0[fir_pkg::MIX_ENDIAN_LSB +: fir_pkg::FLD_W] = fir_pkg::MIX_ENDIAN_VAL;
    // RULE9
    memModel0[fir_pkg::SPACE_ID_LSB +: fir_pkg::FLD_W] = fir_pkg::SPACE_ID_VAL;
    // RULE10
    memModel0[fir_pkg::PHYS_RANGE_LSB +: fir_pkg::FLD_W] = fir_pkg::PHYS_RANGE_VAL;
  end

  // ****************************************
  // Memory model 1
  // ****************************************
  always_comb begin
    memModel1 = '0; // RULE24
    // Upper half reserved, lower half fully populated
    // RULE11
    memModel1[fir_pkg::EXEC_SPLIT_LSB +: fir_pkg::FLD_W] = fir_pkg::EXEC_SPLIT_VAL;
    // RULE12
    memModel1[fir_pkg::SPEC_ERR_LSB +: fir_pkg::FLD_W] = fir_pkg::SPEC_ERR_VAL;
    // RULE13
    memModel1[fir_pkg::PAN_NEVER_LSB +: fir_pkg::FLD_W] = fir_pkg::PAN_NEVER_VAL;
    // RULE14
    memModel1[fir_pkg::ORDER_REG_LSB +: fir_pkg::FLD_W] = fir_pkg::ORDER_REG_VAL;
    // RULE15
    memModel1[fir_pkg::HIER_DIS_LSB +: fir_pkg::FLD_W] = fir_pkg::HIER_DIS_VAL;
    // RULE16
    memModel1[fir_pkg::HOST_EXT_LSB +: fir_pkg::FLD_W] = fir_pkg::HOST_EXT_VAL;
    // RULE17
    memModel1[fir_pkg::VM_ID_LSB +: fir_pkg::FLD_W] = fir_pkg::VM_ID_VAL;
    // RULE18
    memModel1[fir_pkg::HW_FLAG_LSB +: fir_pkg::FLD_W] = fir_pkg::HW_FLAG_VAL;
  end

  // ****************************************
  // Memory model 2
  // ****************************************
  always_comb begin
    memModel2 = '0; // RULE24
    // Only the trap field lives in the upper half
    // RULE19
    memModel2[fir_pkg::ENH_TRAP_LSB +: fir_pkg::FLD_W] = fir_pkg::ENH_TRAP_VAL;
    // RULE20
    memModel2[fir_pkg::VIRT_RANGE_LSB +: fir_pkg::FLD_W] = fir_pkg::VIRT_RANGE_VAL;
    // RULE21
    memModel2[fir_pkg::IMPL_BAR_LSB +: fir_pkg::FLD_W] = fir_pkg::IMPL_BAR_VAL;
    // RULE21 RULE22
    memModel2[fir_pkg::LDST_ORDER_LSB +: fir_pkg::FLD_W] = fir_pkg::LDST_ORDER_VAL;
    // RULE23
    memModel2[fir_pkg::USER_OVR_LSB +: fir_pkg::FLD_W] = fir_pkg::USER_OVR_VAL;
    // RULE23
    memModel2[fir_pkg::COMMON_SH_LSB +: fir_pkg::FLD_W] = fir_pkg::COMMON_SH_VAL;
  end

  assign featTable[0] = instrAttr0;
  assign featTable[1] = instrAttr1;
  assign featTable[2] = memModel0;
  assign featTable[3] = memModel1;
  assign featTable[4] = memModel2;

  // ****************************************
  // Address decode
  // ****************************************
  assign hitFeat   = regAddr < 4'(fir_pkg::NUM_FEAT);
  assign hitCtrl   = regAddr == fir_pkg::IDX_CTRL;
  assign hitStatus = regAddr == fir_pkg::IDX_STATUS;
  assign hitLocal  = hitCtrl || hitStatus;

  // A write to a feature word is never stored; it is counted only while tracking is on
  assign featWrite   = regWrite && hitFeat; // RULE2
  // Unmapped means neither a feature word nor an own register
  assign unmapAccess = (regWrite || regRead) && !hitFeat && !hitLocal;
  // Status write clears everything; its data is ignored
  assign statusClear = regWrite && hitStatus;
  assign trackOn     = ctrl_reg[fir_pkg::CTRL_TRACK_BIT];
  assign satOn       = ctrl_reg[fir_pkg::CTRL_SAT_BIT];

  // ****************************************
  // Control register
  // ****************************************
  // Tracking and saturation start on so early stray writes are caught
  always_comb begin
    ctrl_next = ctrl_reg;
    if (regWrite && hitCtrl) begin
      ctrl_next = regWrData[1:0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= fir_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************
  // Ignored write counter
  // ****************************************
  // Saturation keeps a runaway driver from wrapping to zero
  // With saturation off the count simply wraps
  // Clear first so a set in the same cycle still lands
  always_comb begin
    ignoreCnt_next = ignoreCnt_reg;
    if (statusClear) begin
      ignoreCnt_next = '0;
    end
    if (featWrite && trackOn) begin // RULE2
      if (!(satOn && ignoreCnt_reg == fir_pkg::CNT_MAX)) begin
        ignoreCnt_next = ignoreCnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ignoreCnt_reg <= '0;
    end else begin
      ignoreCnt_reg <= ignoreCnt_next;
    end
  end

  // ****************************************
  // Per-register write stickies
  // ****************************************
  // One sticky per feature word, cleared with the rest of the status
  genvar gi;
  generate
    for (gi = 0; gi < fir_pkg::NUM_FEAT; gi++) begin : g_sticky
      assign featSel[gi] = regAddr == 4'(gi);
      // Set wins over clear in the same cycle
      assign hitSticky_next[gi] = (featWrite && featSel[gi] && trackOn)
                                  || (hitSticky_reg[gi] && !statusClear);
    end
  endgenerate

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hitSticky_reg <= '0;
    end else begin
      hitSticky_reg <= hitSticky_next;
    end
  end

  // ****************************************
  // Unmapped access and summary flags
  // ****************************************
  // Set wins over clear in the same cycle
  always_comb begin
    unmap_next = unmap_reg;
    if (statusClear) begin
      unmap_next = 1'b0;
    end
    if (unmapAccess) begin
      unmap_next = 1'b1;
    end
  end

  // Summary flag, gated by tracking like the counter
  always_comb begin
    roSeen_next = roWriteSeen;
    if (statusClear) begin
      roSeen_next = 1'b0;
    end
    if (featWrite && trackOn) begin
      roSeen_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      unmap_reg <= 1'b0;
    end else begin
      unmap_reg <= unmap_next;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      roWriteSeen <= 1'b0;
    end else begin
      roWriteSeen <= roSeen_next;
    end
  end

  // ****************************************
  // Local read word
  // ****************************************
  always_comb begin
    localWord = '0;
    // Own registers use the low bits only; the rest reads zero
    if (hitCtrl) begin
      localWord[1:0] = ctrl_reg;
    end else if (hitStatus) begin
      localWord[fir_pkg::STAT_CNT_LSB +: fir_pkg::CNT_W]    = ignoreCnt_reg;
      localWord[fir_pkg::STAT_HIT_LSB +: fir_pkg::NUM_FEAT] = hitSticky_reg;
      localWord[fir_pkg::STAT_UNMAP_BIT]                    = unmap_reg;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped reads come back as zero, one cycle later like any other
  // Read register kept apart so the data output is a plain flip-flop
  fir_read_port u_read_port (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .readStrobe   (regRead),
    .readIndex    (regAddr),
    .tableWords   (featTable),
    .localHit     (hitLocal),
    .localWord    (localWord),
    .readData_reg (regRdData)
  );
endmodule // fir_feature_bank
`default_nettype wire

// ### rtl/fir_pkg.sv
`default_nettype none
package fir_pkg;
  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 64;
  localparam int NUM_FEAT = 5;
  localparam int FLD_W = 4;
  localparam int CNT_W = 16;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] IDX_ISAR0 = 4'h0;
  localparam logic [3:0] IDX_ISAR1 = 4'h1;
  localparam logic [3:0] IDX_MMFR0 = 4'h2;
  localparam logic [3:0] IDX_MMFR1 = 4'h3;
  localparam logic [3:0] IDX_MMFR2 = 4'h4;
  localparam logic [3:0] IDX_CTRL = 4'h8;
  localparam logic [3:0] IDX_STATUS = 4'h9;

  // ****************************************
  // Own control and status layout
  // ****************************************
  localparam int CTRL_TRACK_BIT = 0;
  localparam int CTRL_SAT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_HIT_LSB = 16;
  localparam int STAT_UNMAP_BIT = 31;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // ****************************************
  // Instruction attributes 0
  // ****************************************
  localparam int DOT_LSB = 44;
  localparam logic [3:0] DOT_VAL = 4'h1;
  localparam int RDM_LSB = 28;
  localparam logic [3:0] RDM_VAL = 4'h1;
  localparam int ATOMIC_LSB = 20;
  localparam logic [3:0] ATOMIC_VAL = 4'h2;
  localparam int CRC_LSB = 16;
  localparam logic [3:0] CRC_VAL = 4'h1;
  localparam int HASH2_LSB = 12;
  localparam int HASH1_LSB = 8;
  localparam logic [3:0] HASH_ON_VAL = 4'h1;
  localparam int CIPHER_LSB = 4;
  localparam logic [3:0] CIPHER_ON_VAL = 4'h2;
  localparam logic [3:0] ABSENT_VAL = 4'h0;

  // ****************************************
  // Instruction attributes 1
  // ****************************************
  localparam int RC_LOAD_ACQ_LSB = 20;
  localparam logic [3:0] RC_LOAD_ACQ_VAL = 4'h1;
  localparam int PERSIST_CLEAN_LSB = 0;
  localparam logic [3:0] PERSIST_CLEAN_VAL = 4'h1;

  // ****************************************
  // Memory model 0
  // ****************************************
  localparam int SMALL_GRAN_LSB = 28;
  localparam int LARGE_GRAN_LSB = 24;
  localparam logic [3:0] GRAN_4_64_VAL = 4'h0;
  localparam int MID_GRAN_LSB = 20;
  localparam logic [3:0] MID_GRAN_VAL = 4'h1;
  localparam int USER_ENDIAN_LSB = 16;
  localparam logic [3:0] USER_ENDIAN_VAL = 4'h0;
  localparam int SEC_SPLIT_LSB = 12;
  localparam logic [3:0] SEC_SPLIT_VAL = 4'h1;
  localparam int MIX_ENDIAN_LSB = 8;
  localparam logic [3:0] MIX_ENDIAN_VAL = 4'h1;
  localparam int SPACE_ID_LSB = 4;
  localparam logic [3:0] SPACE_ID_VAL = 4'h2;
  localparam int PHYS_RANGE_LSB = 0;
  localparam logic [3:0] PHYS_RANGE_VAL = 4'h5;

  // ****************************************
  // Memory model 1
  // ****************************************
  localparam int EXEC_SPLIT_LSB = 28;
  localparam logic [3:0] EXEC_SPLIT_VAL = 4'h1;
  localparam int SPEC_ERR_LSB = 24;
  localparam logic [3:0] SPEC_ERR_VAL = 4'h0;
  localparam int PAN_NEVER_LSB = 20;
  localparam logic [3:0] PAN_NEVER_VAL = 4'h2;
  localparam int ORDER_REG_LSB = 16;
  localparam logic [3:0] ORDER_REG_VAL = 4'h1;
  localparam int HIER_DIS_LSB = 12;
  localparam logic [3:0] HIER_DIS_VAL = 4'h2;
  localparam int HOST_EXT_LSB = 8;
  localparam logic [3:0] HOST_EXT_VAL = 4'h1;
  localparam int VM_ID_LSB = 4;
  localparam logic [3:0] VM_ID_VAL = 4'h2;
  localparam int HW_FLAG_LSB = 0;
  localparam logic [3:0] HW_FLAG_VAL = 4'h2;

  // ****************************************
  // Memory model 2
  // ****************************************
  localparam int ENH_TRAP_LSB = 56;
  localparam logic [3:0] ENH_TRAP_VAL = 4'h1;
  localparam int VIRT_RANGE_LSB = 16;
  localparam logic [3:0] VIRT_RANGE_VAL = 4'h0;
  localparam int IMPL_BAR_LSB = 12;
  localparam logic [3:0] IMPL_BAR_VAL = 4'h1;
  localparam int LDST_ORDER_LSB = 8;
  localparam logic [3:0] LDST_ORDER_VAL = 4'h0;
  localparam int USER_OVR_LSB = 4;
  localparam logic [3:0] USER_OVR_VAL = 4'h1;
  localparam int COMMON_SH_LSB = 0;
  localparam logic [3:0] COMMON_SH_VAL = 4'h1;
endpackage
`default_nettype wire

// ### rtl/fir_read_port.sv
`timescale 1ns/1ns
`default_nettype none
module fir_read_port (
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire logic                        readStrobe,
  input  wire logic [fir_pkg::ADDR_W-1:0]  readIndex,
  input  wire logic [fir_pkg::NUM_FEAT-1:0][fir_pkg::DATA_W-1:0] tableWords,
  input  wire logic                        localHit,
  input  wire logic [fir_pkg::DATA_W-1:0]  localWord,
  output var  logic [fir_pkg::DATA_W-1:0]  readData_reg
);
  logic [fir_pkg::DATA_W-1:0] readData_next;

  // Data stands only in the cycle after the strobe
  always_comb begin
    readData_next = '0;
    if (readStrobe) begin
      if (localHit) begin
        readData_next = localWord;
      end else if (readIndex < 4'(fir_pkg::NUM_FEAT)) begin
        readData_next = tableWords[readIndex[2:0]];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      readData_reg <= '0;
    end else begin
      readData_reg <= readData_next;
    end
  end
endmodule // fir_read_port
`default_nettype wire

// ### verification/fir_feature_bank_properties.sv
`timescale 1ns/1ns
`default_nettype none
module fir_feature_bank_properties #(
  parameter bit CRYPTO_PRESENT = 1'b1
) (
  input wire logic                       clock,
  input wire logic                       sys_rst,
  input wire logic [fir_pkg::ADDR_W-1:0] regAddr,
  input wire logic [fir_pkg::DATA_W-1:0] regWrData,
  input wire logic                       regWrite,
  input wire logic                       regRead,
  input wire logic [fir_pkg::DATA_W-1:0] regRdData,
  input wire logic                       roWriteSeen
);
  // ****************************************
  // Expected identification words
  // ****************************************
  localparam logic [63:0] ISA0_WORD = CRYPTO_PRESENT ? 64'h0000_1000_1021_1120
                                                     : 64'h0000_1000_1021_0000;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  logic trackMirror_reg;

  // Tracking enable rebuilt from the bus, so tracked writes can be told apart
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      trackMirror_reg <= fir_pkg::CTRL_RESET[fir_pkg::CTRL_TRACK_BIT];
    end else if (regWrite && regAddr == fir_pkg::IDX_CTRL) begin
      trackMirror_reg <= regWrData[fir_pkg::CTRL_TRACK_BIT];
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  chk_isa0_word: assert property (
    regRead && regAddr == fir_pkg::IDX_ISAR0 |=> regRdData == ISA0_WORD)
    else $error("instruction attributes 0 word wrong");
  chk_isa1_word: assert property (
    regRead && regAddr == fir_pkg::IDX_ISAR1 |=> regRdData == 64'h0000_0000_0010_0001)
    else $error("instruction attributes 1 word wrong");
  chk_mm0_word: assert property (
    regRead && regAddr == fir_pkg::IDX_MMFR0 |=> regRdData == 64'h0000_0000_0010_1125)
    else $error("memory model 0 word wrong");
  chk_mm1_word: assert property (
    regRead && regAddr == fir_pkg::IDX_MMFR1 |=> regRdData == 64'h0000_0000_1021_2122)
    else $error("memory model 1 word wrong");
  chk_mm2_word: assert property (
    regRead && regAddr == fir_pkg::IDX_MMFR2 |=> regRdData == 64'h0100_0000_0000_1011)
    else $error("memory model 2 word wrong");
  chk_unmapped_zero: assert property (
    regRead && (regAddr inside {[4'h5:4'h7], [4'hA:4'hF]}) |=> regRdData == 64'h0)
    else $error("unmapped read not zero");
  chk_idle_zero: assert property (
    !regRead |=> regRdData == 64'h0)
    else $error("read data present without read");

  // ****************************************
  // Ignored writes
  // ****************************************
  chk_write_flag: assert property (
    regWrite && regAddr <= fir_pkg::IDX_MMFR2 && trackMirror_reg |=> roWriteSeen)
    else $error("feature write not flagged");
  chk_flag_cause: assert property (
    $rose(roWriteSeen) |-> $past(regWrite) && $past(regAddr) <= fir_pkg::IDX_MMFR2
      && $past(trackMirror_reg))
    else $error("write flag rose without feature write");
  chk_untracked_quiet: assert property (
    regWrite && regAddr <= fir_pkg::IDX_MMFR2 && !trackMirror_reg && !roWriteSeen
      |=> !roWriteSeen)
    else $error("feature write flagged with tracking off");
endmodule // fir_feature_bank_properties

bind fir_feature_bank fir_feature_bank_properties #(
  .CRYPTO_PRESENT(CRYPTO_PRESENT)
) u_fir_feature_bank_properties (
  .clock       (clock),
  .sys_rst     (sys_rst),
  .regAddr     (regAddr),
  .regWrData   (regWrData),
  .regWrite    (regWrite),
  .regRead     (regRead),
  .regRdData   (regRdData),
  .roWriteSeen (roWriteSeen)
);
`default_nettype wire

// ### verification/fir_feature_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fir_feature_bank_tb;
  logic                       clock;
  logic                       sys_rst;
  logic [fir_pkg::ADDR_W-1:0] regAddr;
  logic [fir_pkg::DATA_W-1:0] regWrData;
  logic                       regWrite;
  logic                       regRead;
  logic [fir_pkg::DATA_W-1:0] regRdData;
  logic                       roWriteSeen;
  int                         failCount;
  int                         checks;
  int                         cycles;
  logic [63:0]                expWord [5];

  fir_feature_bank #(.CRYPTO_PRESENT(1'b1)) u_fir_feature_bank (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .regAddr     (regAddr),
    .regWrData   (regWrData),
    .regWrite    (regWrite),
    .regRead     (regRead),
    .regRdData   (regRdData),
    .roWriteSeen (roWriteSeen)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [63:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic write_reg(input logic [3:0] a, input logic [63:0] d);
    @(posedge clock);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic check_field(input logic [3:0] idx, input int lsb, input logic [3:0] exp);
    logic [63:0] d;
    read_reg(idx, d);
    compare(64'(d[lsb+:4]), 64'(exp));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_fields();
    check_field(4'h0, 4, 4'h2);
    check_field(4'h1, 20, 4'h1);
    check_field(4'h1, 0, 4'h1);
    check_field(4'h2, 28, 4'h0);
    check_field(4'h2, 24, 4'h0);
    check_field(4'h2, 20, 4'h1);
    check_field(4'h2, 16, 4'h0);
    check_field(4'h2, 12, 4'h1);
    check_field(4'h2, 8, 4'h1);
    check_field(4'h2, 4, 4'h2);
    check_field(4'h2, 0, 4'h5);
    check_field(4'h3, 28, 4'h1);
    check_field(4'h3, 24, 4'h0);
    check_field(4'h3, 20, 4'h2);
    check_field(4'h3, 16, 4'h1);
    check_field(4'h3, 12, 4'h2);
    check_field(4'h3, 8, 4'h1);
    check_field(4'h3, 4, 4'h2);
    check_field(4'h3, 0, 4'h2);
    check_field(4'h4, 56, 4'h1);
    check_field(4'h4, 16, 4'h0);
    check_field(4'h4, 12, 4'h1);
    check_field(4'h4, 8, 4'h0);
    check_field(4'h4, 4, 4'h1);
    check_field(4'h4, 0, 4'h1);
  endtask

  // Strobes with no gap; each word lands one cycle after its strobe
  task automatic test_back_to_back();
    for (int i = 0; i <= 5; i++) begin
      @(posedge clock);
      regRead <= (i < 5);
      regAddr <= 4'(i);
      if (i > 0) begin
        #1 compare(regRdData, expWord[i-1]);
      end
    end
    @(posedge clock);
    #1 compare(regRdData, 64'h0);
  endtask

  task automatic test_writes_ignored();
    logic [63:0] d;
    compare(64'(roWriteSeen), 64'h0);
    for (int i = 0; i < 5; i++) begin
      write_reg(4'(i), ~expWord[i]);
      read_reg(4'(i), d);
      compare(d, expWord[i]);
    end
    compare(64'(roWriteSeen), 64'h1);
    read_reg(fir_pkg::IDX_STATUS, d);
    compare(d, 64'h0000_0000_001F_0005);
  endtask

  task automatic test_unmapped();
    logic [63:0] d;
    logic [3:0]  holes [5] = '{4'h5, 4'h6, 4'h7, 4'hA, 4'hF};
    write_reg(fir_pkg::IDX_STATUS, 64'h0);
    write_reg(4'h6, 64'hFFFF_FFFF_FFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      read_reg(holes[i], d);
      compare(d, 64'h0);
    end
    read_reg(fir_pkg::IDX_STATUS, d);
    compare(d, 64'h0000_0000_8000_0000);
  endtask

  // With tracking off a feature write leaves no trace at all
  task automatic test_tracking_off();
    logic [63:0] d;
    write_reg(fir_pkg::IDX_STATUS, 64'h0);
    write_reg(fir_pkg::IDX_CTRL, 64'h0);
    read_reg(fir_pkg::IDX_CTRL, d);
    compare(d, 64'h0);
    write_reg(fir_pkg::IDX_ISAR0, 64'hFFFF_FFFF_FFFF_FFFF);
    read_reg(fir_pkg::IDX_ISAR0, d);
    compare(d, expWord[0]);
    compare(64'(roWriteSeen), 64'h0);
    read_reg(fir_pkg::IDX_STATUS, d);
    compare(d, 64'h0);
  endtask

  // Second reset mid-run must clear flags, return control to CTRL_RESET and leave the fixed words alone
  task automatic test_reset_again();
    logic [63:0] d;
    write_reg(fir_pkg::IDX_CTRL, 64'h1);
    write_reg(fir_pkg::IDX_ISAR1, 64'h0);
    #1 compare(64'(roWriteSeen), 64'h1);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    #1 compare(64'(roWriteSeen), 64'h0);
    @(posedge clock);
    sys_rst <= 1'b0;
    read_reg(fir_pkg::IDX_CTRL, d);
    compare(d, 64'(fir_pkg::CTRL_RESET));
    read_reg(fir_pkg::IDX_STATUS, d);
    compare(d, 64'h0);
    read_reg(fir_pkg::IDX_MMFR2, d);
    compare(d, expWord[4]);
  endtask

  // ****************************************
  // Closing and sequence
  // ****************************************
  task automatic give_verdict();
    $display("checks=%0d failCount=%0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 125 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failCount++;
      give_verdict();
    end
  end

  initial begin
    sys_rst   = 1'b1;
    regAddr   = 4'h0;
    regWrData = 64'h0;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    failCount = 0;
    checks    = 0;
    cycles    = 0;
    expWord   = '{64'h0000_1000_1021_1120, 64'h0000_0000_0010_0001,
                  64'h0000_0000_0010_1125, 64'h0000_0000_1021_2122,
                  64'h0100_0000_0000_1011};
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    test_fields();
    test_back_to_back();
    test_writes_ignored();
    test_unmapped();
    test_tracking_off();
    test_reset_again();
    give_verdict();
  end
endmodule // fir_feature_bank_tb
`default_nettype wire
